// *** adc_scan_sequencer_control.sv ***
// Analog-input scan sequencer, control/status and clear registers on APB
////////////////////////////////////////////////////////////////////////////
// How it works
// - Start bits 3:0, stop bits 11:8
// - Scan register write reloads current channel
// - Each trigger advances; after stop, restart
// - Channel numbers wrap from fifteen to zero
// - Start field addresses per-channel settings memory
// - Differential even pairs odd; even settings apply
// - Differential even channel skips its odd partner
// - Three-bit mode selects single through about
// - Clock select: internal pacer or pin
// - Trigger select: digital pin or analog
// - Edge bit: rising when 0, falling 1
// - Calibration bit reroutes inputs 0,2,4,6
// - Terminal-count flag bit 14; write 1 sets
// - Trigger flag bit 15; write 1 sets
// - Any low-byte clear write clears interrupt
// - Clear bit 11 written 0 flushes input
// - Clear bit 15 written 0 flushes output
// - Single mode: start write converts once
// - Sample word flag marks post-trigger samples
module adc_scan_sequencer_control
    import adc_scan_pkg::*;
#(
    parameter int NCH       = 16,
    parameter int PACER_DIV = PACER_DIV_DEFAULT
) (
    input  wire logic        pclk,                       // Bus clock
    input  wire logic        presetn,                    // Async reset, low
    input  wire logic        psel,                       // APB select
    input  wire logic        penable,                    // APB access phase
    input  wire logic        pwrite,                     // APB direction
    input  wire logic [7:0]  paddr,                      // APB byte address
    input  wire logic [31:0] pwdata,                     // APB write data
    input  wire logic [3:0]  pstrb,                      // APB byte strobes
    output logic      [31:0] prdata,                     // APB read data
    output logic             pready,                     // APB ready
    output logic             pslverr,                    // APB error
    input  wire logic        external_sample_clock_pin,  // Pin, async
    input  wire logic        digital_trigger_pin,        // Pin, async
    input  wire logic        analog_trigger_pin,         // Comparator, async
    input  wire logic        dma_terminal_count,         // DMA counter pulse
    input  wire logic        conv_done,                  // Converter result
    input  wire logic [11:0] conv_data,                  // Converter value
    output logic             conversion_start,           // One-cycle pulse
    output logic      [3:0]  mux_pos_chan,               // Positive input
    output logic      [3:0]  mux_neg_chan,               // Negative input
    output logic             mux_differential,           // Pair in use
    output logic      [2:0]  gain_code,                  // Gain for channel
    output logic             unipolar,                   // Polarity
    output logic             calibration_routing,        // Cal wiring on
    output logic             flush_sample_fifo,          // One-cycle pulse
    output logic             flush_output_fifo,          // One-cycle pulse
    output logic             irq_clear,                  // One-cycle pulse
    output logic             sample_valid,               // One-cycle pulse
    output logic      [15:0] sample_word,                // Data+chan+flag
    output logic             scan_setup_error            // Bad diff pairing
);

    ////////////////////////////////////////////////////////////////////////
    // Register state

    logic [3:0]     scan_first_channel_r;   // Scan start
    logic [3:0]     scan_last_channel_r;    // Scan stop
    logic [3:0]     cur_chan_r;             // Channel for next conversion
    logic [3:0]     next_chan;              // From the step logic
    logic [2:0]     acquisition_mode_select_r;
    logic           sample_clock_select_r;  // 0 pacer, 1 pin
    logic           trigger_source_select_r;
    logic           trigger_edge_select_r;
    logic           transfer_count_done_flag_r;
    logic           input_trigger_seen_flag_r;
    logic [2:0]     gain_mem_r [NCH];       // Per-channel gain
    logic [NCH-1:0] uni_mem_r;              // Per-channel polarity
    logic [NCH-1:0] diff_mem_r;             // Per-channel input type
    logic [3:0]     conv_chan_r;            // Channel of conversion in flight

    ////////////////////////////////////////////////////////////////////////
    // APB decode

    logic [3:0] idx;        // Register index of the access
    logic       setup_ph;   // Setup cycle
    logic       wr_go;      // Write takes effect now
    logic       mapped;     // Address hits a register

    // Map a byte address to an index; any stray low bits miss
    function automatic logic hit(input logic [7:0] a, input logic [3:0] i);
        hit = (a == {2'b00, i, 2'b00});
    endfunction : hit

    // Whether an address belongs to the register file
    always_comb begin
        idx      = paddr[ADDR_SHIFT +: 4];
        setup_ph = psel && !penable;
        wr_go    = psel && penable && pready && pwrite && !pslverr;
        mapped   = hit(paddr, IDX_CONV_START) || hit(paddr, IDX_RANGE_SET)
                || hit(paddr, IDX_SCAN_RANGE) || hit(paddr, IDX_CTRL_STAT)
                || hit(paddr, IDX_CLEAR);
    end

    // Ready and error answered one cycle after setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup_ph;
            pslverr <= setup_ph && !mapped;
        end
    end

    // Read data prepared during setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup_ph && !pwrite) begin
            prdata <= 32'h0000_0000;
            if (hit(paddr, IDX_CTRL_STAT)) begin
                prdata[MODE_LSB +: 3] <= acquisition_mode_select_r;
                prdata[CLKSEL_BIT]    <= sample_clock_select_r;
                prdata[TRSRC_BIT]     <= trigger_source_select_r;
                prdata[EDGE_BIT]      <= trigger_edge_select_r;
                prdata[TCF_BIT]       <= transfer_count_done_flag_r;
                prdata[TRGF_BIT]      <= input_trigger_seen_flag_r;
            end else if (hit(paddr, IDX_CONV_START)) begin
                prdata[15:0] <= sample_word;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and edges

    logic [2:0] pin_s1;     // First stage, read only by second
    logic [2:0] pin_s2;     // Second stage
    logic [2:0] pin_s3;     // Delayed copy for edge detection

    // Two flops on every asynchronous input
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1 <= 3'h0;
            pin_s2 <= 3'h0;
            pin_s3 <= 3'h0;
        end else begin
            pin_s1 <= {analog_trigger_pin, digital_trigger_pin,
                       external_sample_clock_pin};
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end

    logic trig_lvl;     // Selected trigger source, synced
    logic trig_prev;
    logic trig_event;   // Selected edge seen
    logic ext_tick;     // Rising edge of external sample clock

    // Trigger source and edge selection
    always_comb begin
        trig_lvl  = trigger_source_select_r ? pin_s2[2] : pin_s2[1];
        trig_prev = trigger_source_select_r ? pin_s3[2] : pin_s3[1];
        trig_event = trigger_edge_select_r ? (trig_prev && !trig_lvl)
                                           : (!trig_prev && trig_lvl);
        ext_tick  = pin_s2[0] && !pin_s3[0];
    end

    ////////////////////////////////////////////////////////////////////////
    // Internal pacer

    localparam int PW = $clog2(PACER_DIV + 1);
    localparam logic [PW-1:0] PACER_LAST = PW'(PACER_DIV - 1);
    logic [PW-1:0] pacer_cnt_r;     // Divider count
    logic          pacer_tick_r;    // One-cycle enable

    // Divide the bus clock down to the pacer rate
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pacer_cnt_r  <= '0;
            pacer_tick_r <= 1'b0;
        end else if (pacer_cnt_r == PACER_LAST) begin
            pacer_cnt_r  <= '0;
            pacer_tick_r <= 1'b1;
        end else begin
            pacer_cnt_r  <= pacer_cnt_r + PW'(1);
            pacer_tick_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Conversion trigger

    logic sample_tick;  // Selected sample clock
    logic start_wr;     // Write to the start register
    logic conv_go;      // Start a conversion now

    // Choose what starts a conversion in each mode
    always_comb begin
        sample_tick = sample_clock_select_r ? ext_tick : pacer_tick_r;
        start_wr    = wr_go && idx == IDX_CONV_START;
        case (acq_mode_e'(acquisition_mode_select_r))
            MODE_SINGLE: conv_go = start_wr;
            MODE_PACER:  conv_go = sample_tick;
            MODE_POST:   conv_go = sample_tick && input_trigger_seen_flag_r;
            MODE_DELAY:  conv_go = sample_tick && input_trigger_seen_flag_r;
            MODE_ABOUT:  conv_go = sample_tick;
            default:     conv_go = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Scan range and sequencer

    // Scan range register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scan_first_channel_r <= CHAN0;
            scan_last_channel_r  <= CHAN0;
        end else if (wr_go && idx == IDX_SCAN_RANGE) begin
            scan_first_channel_r <= pwdata[FIRST_LSB +: 4];
            scan_last_channel_r  <= pwdata[LAST_LSB +: 4];
        end
    end

    scan_step #(
        .NCH (NCH)
    ) u_step (
        .cur_chan   (cur_chan_r),
        .first_chan (scan_first_channel_r),
        .last_chan  (scan_last_channel_r),
        .diff_map   (diff_mem_r),
        .next_chan  (next_chan)
    );

    // Current channel: a scan range write wins over a trigger
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur_chan_r <= CHAN0;
        end else if (wr_go && idx == IDX_SCAN_RANGE) begin
            cur_chan_r <= pwdata[FIRST_LSB +: 4];
        end else if (conv_go) begin
            cur_chan_r <= next_chan;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-channel settings memory

    // Range write lands at the start-channel pointer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NCH; i++) begin
                gain_mem_r[i] <= 3'h0;
            end
            uni_mem_r  <= '0;
            diff_mem_r <= '0;
        end else if (wr_go && idx == IDX_RANGE_SET) begin
            gain_mem_r[scan_first_channel_r] <= pwdata[GAIN_LSB +: 3];
            uni_mem_r[scan_first_channel_r]  <= pwdata[UNI_BIT];
            diff_mem_r[scan_first_channel_r] <= pwdata[DIFF_BIT];
        end
    end

    logic [NCH/2-1:0] pair_bad;     // Single even with differential odd

    // Check each even/odd pair for the forbidden setup
    genvar gp;
    generate
        for (gp = 0; gp < NCH / 2; gp++) begin : g_pair
            assign pair_bad[gp] = !diff_mem_r[2*gp] && diff_mem_r[2*gp+1];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Control/status register

    logic ctrl_wr;  // Write to control/status
    assign ctrl_wr = wr_go && idx == IDX_CTRL_STAT;

    // Mode, clock, trigger and calibration settings
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acquisition_mode_select_r <= 3'h0;
            sample_clock_select_r     <= 1'b0;
            trigger_source_select_r   <= 1'b0;
            trigger_edge_select_r     <= 1'b0;
            calibration_routing       <= 1'b0;
        end else if (ctrl_wr) begin
            acquisition_mode_select_r <= pwdata[MODE_LSB +: 3];
            sample_clock_select_r     <= pwdata[CLKSEL_BIT];
            trigger_source_select_r   <= pwdata[TRSRC_BIT];
            trigger_edge_select_r     <= pwdata[EDGE_BIT];
            calibration_routing       <= pwdata[CAL_BIT];
        end
    end

    // Terminal-count flag: hardware or write 1 sets, write 0 clears
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            transfer_count_done_flag_r <= 1'b0;
        end else if (dma_terminal_count) begin
            transfer_count_done_flag_r <= 1'b1;
        end else if (ctrl_wr) begin
            transfer_count_done_flag_r <= pwdata[TCF_BIT];
        end
    end

    // Trigger flag: selected edge or write 1 sets; set beats clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            input_trigger_seen_flag_r <= 1'b0;
        end else if (trig_event) begin
            input_trigger_seen_flag_r <= 1'b1;
        end else if (ctrl_wr) begin
            input_trigger_seen_flag_r <= pwdata[TRGF_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Clear register pulses

    logic clr_wr;   // Write to the clear register
    assign clr_wr = wr_go && idx == IDX_CLEAR;

    // One-cycle clear strobes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_clear         <= 1'b0;
            flush_sample_fifo <= 1'b0;
            flush_output_fifo <= 1'b0;
        end else begin
            irq_clear         <= clr_wr && pstrb[0];
            flush_sample_fifo <= clr_wr && pstrb[1]
                                 && !pwdata[FLUSH_IN_BIT];
            flush_output_fifo <= clr_wr && pstrb[1]
                                 && !pwdata[FLUSH_OUT_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Multiplexer outputs and conversion start

    // Drive mux from current channel; pair uses even settings
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mux_pos_chan     <= CHAN0;
            mux_neg_chan     <= CHAN0;
            mux_differential <= 1'b0;
            gain_code        <= 3'h0;
            unipolar         <= 1'b0;
            scan_setup_error <= 1'b0;
        end else begin
            if (diff_mem_r[cur_chan_r] && !cur_chan_r[0]) begin
                mux_pos_chan     <= cur_chan_r | 4'h1;
                mux_neg_chan     <= cur_chan_r;
                mux_differential <= 1'b1;
            end else begin
                mux_pos_chan     <= cur_chan_r;
                mux_neg_chan     <= cur_chan_r;
                mux_differential <= 1'b0;
            end
            gain_code        <= gain_mem_r[cur_chan_r];
            unipolar         <= uni_mem_r[cur_chan_r];
            scan_setup_error <= |pair_bad;
        end
    end

    // Start pulse and channel of the conversion in flight
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conversion_start <= 1'b0;
            conv_chan_r      <= CHAN0;
        end else begin
            conversion_start <= conv_go;
            if (conv_go) begin
                conv_chan_r <= cur_chan_r;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sample word assembly

    // Tag each result with channel and post-trigger flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sample_word  <= ZERO16;
            sample_valid <= 1'b0;
        end else begin
            sample_valid <= conv_done;
            if (conv_done) begin
                sample_word[DATA_W-1:0]     <= conv_data;
                sample_word[CHAN_LSB +: 3]  <= conv_chan_r[2:0];
                sample_word[FLAG_BIT]       <= input_trigger_seen_flag_r;
            end
        end
    end

endmodule : adc_scan_sequencer_control

// *** adc_scan_pkg.sv ***
// Constants for the analog-input scan and control block
package adc_scan_pkg;

    // Register indices; byte address is four times the index
    localparam logic [3:0] IDX_CONV_START  = 4'h0;
    localparam logic [3:0] IDX_RANGE_SET   = 4'h2;
    localparam logic [3:0] IDX_SCAN_RANGE  = 4'h4;
    localparam logic [3:0] IDX_CTRL_STAT   = 4'h6;
    localparam logic [3:0] IDX_CLEAR       = 4'h8;
    localparam int         ADDR_SHIFT      = 2;

    // Scan range register fields
    localparam int FIRST_LSB = 0;
    localparam int LAST_LSB  = 8;

    // Range setting register fields
    localparam int GAIN_LSB  = 0;
    localparam int UNI_BIT   = 4;
    localparam int DIFF_BIT  = 5;

    // Control/status register fields
    localparam int MODE_LSB  = 0;
    localparam int CLKSEL_BIT = 3;
    localparam int TRSRC_BIT = 4;
    localparam int EDGE_BIT  = 6;
    localparam int CAL_BIT   = 7;
    localparam int TCF_BIT   = 14;
    localparam int TRGF_BIT  = 15;

    // Clear register fields
    localparam int FLUSH_IN_BIT  = 11;
    localparam int FLUSH_OUT_BIT = 15;

    // Sample word fields
    localparam int DATA_W    = 12;
    localparam int CHAN_LSB  = 12;
    localparam int FLAG_BIT  = 15;

    // Reset values
    localparam logic [15:0] ZERO16 = 16'h0000;
    localparam logic [3:0]  CHAN0  = 4'h0;

    // Internal pacer
    localparam int PACER_DIV_DEFAULT = 100;

    // Acquisition modes
    typedef enum logic [2:0] {
        MODE_SINGLE = 3'b000,
        MODE_PACER  = 3'b001,
        MODE_POST   = 3'b010,
        MODE_DELAY  = 3'b011,
        MODE_ABOUT  = 3'b100
    } acq_mode_e;

endpackage : adc_scan_pkg

// *** scan_step.sv ***
// Next-channel computation for the scan sequencer
module scan_step
    import adc_scan_pkg::*;
#(
    parameter int NCH = 16
) (
    input  wire logic [3:0]     cur_chan,      // Channel the next conversion start uses
    input  wire logic [3:0]     first_chan,    // Scan start
    input  wire logic [3:0]     last_chan,     // Scan stop
    input  wire logic [NCH-1:0] diff_map,      // Differential bit per channel
    output logic      [3:0]     next_chan      // Channel after cur_chan in the scan
);

    logic       pair_here;  // Current even channel is a differential pair
    logic [3:0] plus_one;   // Wraps naturally at 4 bits
    logic [3:0] plus_two;

    // Pick the following channel, skipping an odd partner
    always_comb begin
        plus_one  = cur_chan + 4'h1;
        plus_two  = cur_chan + 4'h2;
        pair_here = diff_map[cur_chan] && !cur_chan[0];
        if (cur_chan == last_chan) begin
            next_chan = first_chan;
        end else if (pair_here && plus_one == last_chan) begin
            next_chan = first_chan;
        end else if (pair_here) begin
            next_chan = plus_two;
        end else begin
            next_chan = plus_one;
        end
    end

endmodule : scan_step

// *** adc_scan_sequencer_control_assertions.sv ***
// Port checker for the analog-input scan sequencer block
module adc_scan_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic        pready,
    input wire logic        conv_done,
    input wire logic        sample_valid,
    input wire logic        irq_clear,
    input wire logic        flush_sample_fifo,
    input wire logic        flush_output_fifo,
    input wire logic        calibration_routing,
    input wire logic [3:0]  mux_pos_chan,
    input wire logic [3:0]  mux_neg_chan,
    input wire logic        mux_differential
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Completed writes and the clear-register requests they carry
    wire wr   = psel && penable && pready && pwrite;
    wire clr  = wr && paddr == 8'h20;
    wire fin  = clr && pstrb[1] && !pwdata[11];
    wire fout = clr && pstrb[1] && !pwdata[15];
    sequence s_scan_wr; wr && paddr == 8'h10; endsequence
    sequence s_pulse(sig); sig ##1 !sig; endsequence
    property p_scan_load;
        s_scan_wr ##2 1'b1 |-> mux_neg_chan == $past(pwdata[3:0], 2);
    endproperty
    a_scan_load: assert property (p_scan_load) else $error("scan load");
    property p_diff; mux_differential |-> !mux_neg_chan[0]
        && mux_pos_chan == mux_neg_chan + 4'h1; endproperty
    a_diff: assert property (p_diff) else $error("diff pair");
    property p_single; !mux_differential |-> mux_pos_chan == mux_neg_chan;
    endproperty
    a_single: assert property (p_single) else $error("single");
    property p_irq; clr && pstrb[0] |=> s_pulse(irq_clear); endproperty
    a_irq: assert property (p_irq) else $error("irq clear");
    property p_fin; fin |=> s_pulse(flush_sample_fifo); endproperty
    a_fin: assert property (p_fin) else $error("flush in");
    property p_fout; fout |=> s_pulse(flush_output_fifo); endproperty
    a_fout: assert property (p_fout) else $error("flush out");
    property p_cal; wr && paddr == 8'h18 |=>
        calibration_routing == $past(pwdata[7]); endproperty
    a_cal: assert property (p_cal) else $error("cal bit");
    property p_smp; conv_done |=> sample_valid; endproperty
    a_smp: assert property (p_smp) else $error("sample");
endmodule : adc_scan_checker

// *** conv_model.sv ***
// Converter model answering each conversion request after a delay
module conv_model #(
    parameter int LAT = 3
) (
    input  wire logic        clk,
    input  wire logic        conversion_start,
    output logic             conv_done,
    output logic      [11:0] conv_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [11:0] val = 12'h5a0; // Next result, counts up
    int          cnt = 0;       // Cycles until the result
    initial conv_done = 1'b0;
    initial conv_data = 12'h000;
    // Result stands one cycle; the data line toggles otherwise
    always @(posedge clk) begin
        conv_done <= cnt == 1;
        conv_data <= cnt == 1 ? val : ~conv_data;
        if (cnt == 1)
            val <= val + 12'h1;
        cnt <= conversion_start ? LAT : (cnt > 0 ? cnt - 1 : 0);
    end
endmodule : conv_model

// *** adc_scan_sequencer_control_test.sv ***
// Self-checking bench for the scan sequencer control block
module adc_scan_sequencer_control_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic pready, pslverr, sample_valid, conv_done, cst, dma = 0, uni, serr;
    logic [7:0]  paddr = 0;
    logic [31:0] pwdata = 0, prdata, c;
    logic [3:0]  pstrb = 0, mux_pos_chan, dch[2] = '{4'he, 4'h2};
    logic [1:0]  trg = 0;
    logic [2:0]  gain_code, seq[5] = '{6, 0, 1, 2, 6};
    logic [11:0] conv_data;
    logic [15:0] sample_word, smp_q[$];
    logic [32:0] e, rd_q[$];
    bit          s, eg;
    int          n_fail = 0, samples_checked = 0, k = 0;
    always #5 pclk = ~pclk;
    adc_scan_sequencer_control #(.PACER_DIV(4)) u_adc_scan_sequencer_control (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .external_sample_clock_pin(1'b0),
        .digital_trigger_pin(trg[0]), .analog_trigger_pin(trg[1]),
        .dma_terminal_count(dma), .conv_done, .conv_data,
        .conversion_start(cst), .mux_pos_chan, .mux_neg_chan(),
        .mux_differential(), .gain_code, .unipolar(uni),
        .calibration_routing(), .flush_sample_fifo(), .flush_output_fifo(),
        .irq_clear(), .sample_valid, .sample_word, .scan_setup_error(serr));
    conv_model u_conv_model (.clk(pclk), .conversion_start(cst), .conv_done,
        .conv_data);
    task automatic chk(string nm, logic [32:0] x, logic [32:0] g);
        samples_checked++;
        if (g !== x) begin
            n_fail++;
            $display("mismatch %s exp %h got %h", nm, x, g);
        end
    endtask : chk
    // Results are compared against the oldest note as they appear
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            e = rd_q.pop_front();
            chk("read", e, {pslverr, e[32] ? e[31:0] : prdata});
        end
        if (sample_valid === 1'b1)
            chk("sample", 33'(smp_q.pop_front()),
                33'(sample_word));
    end
    task automatic cyc(int n);
        repeat (n) @(posedge pclk);
    endtask : cyc
    // One bus transfer; a read notes its expected value first
    task automatic apb(bit w, logic [7:0] a, logic [31:0] d,
                       logic [3:0] b = 4'hf, logic [32:0] x = 0);
        if (!w)
            rd_q.push_back(x);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= b;
        @(posedge pclk) penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 0;
        penable <= 0;
        cyc(1);
    endtask : apb
    task automatic conv(logic [2:0] ch, logic f);
        smp_q.push_back({f, ch, 12'h5a0 + 12'(k)});
        k++;
        apb(1, 8'h00, $urandom);
        wait (smp_q.size() == 0);
        cyc(1);
    endtask : conv
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_of_test
    initial begin
        cyc(20000);
        n_fail++;
        end_of_test();
    end
    initial begin
        void'($urandom(22));
        cyc(8);
        presetn <= 1;
        cyc(1);
        apb(0, 8'h0c, 0, 4'hf, 33'h100000000);
        apb(0, 8'h10, 0, 4'hf, 0);
        for (int m = 0; m < 5; m++) begin
            c = $urandom & 32'hd0 | 32'h8 | 32'(m);
            apb(1, 8'h18, c);
            apb(0, 8'h18, 0, 4'hf, {1'b0, c & 32'h5f});
        end
        $display("register test done");
        apb(1, 8'h18, 32'h8);
        // Odd channel differential beside a single even one is flagged
        apb(1, 8'h10, 32'h0101);
        apb(1, 8'h08, 32'h20);
        cyc(2);
        chk("err", 33'h1, 33'(serr));
        apb(1, 8'h08, 32'h0);
        foreach (dch[i]) begin
            apb(1, 8'h10, {20'h0, dch[i], 4'h0, dch[i]});
            apb(1, 8'h08, 32'h33);
        end
        cyc(2);
        chk("gain", 33'h3, 33'(gain_code));
        chk("uni", 33'h1, 33'(uni));
        chk("err", 33'h0, 33'(serr));
        apb(1, 8'h10, 32'h030e);
        cyc(2);
        chk("pos", 33'hf, 33'(mux_pos_chan));
        foreach (seq[i])
            conv(seq[i], 0);
        $display("scan test done");
        for (int i = 0; i < 4; i++) begin
            s = i[0];
            eg = i[1];
            c = 32'h8 | 32'(s) << 4 | 32'(eg) << 6;
            trg <= {2{~eg}};
            cyc(6);
            apb(1, 8'h18, c);
            trg <= {2{eg}};
            cyc(6);
            trg[!s] <= ~eg;
            cyc(6);
            apb(0, 8'h18, 0, 4'hf, {1'b0, c});
            trg[s] <= ~eg;
            cyc(6);
            apb(0, 8'h18, 0, 4'hf, {1'b0, c | 32'h8000});
        end
        $display("trigger test done");
        apb(1, 8'h18, 32'h4008);
        apb(0, 8'h18, 0, 4'hf, 33'h4008);
        apb(1, 8'h18, 32'h8008);
        apb(0, 8'h18, 0, 4'hf, 33'h8008);
        dma <= 1;
        cyc(1);
        dma <= 0;
        cyc(2);
        apb(0, 8'h18, 0, 4'hf, 33'hc008);
        conv(3'h0, 1);
        $display("flag test done");
        repeat (4) apb(1, 8'h20, $urandom & 32'h77ff, 4'($urandom) | 4'h2);
        $display("clear test done");
        end_of_test();
    end
endmodule : adc_scan_sequencer_control_test
bind adc_scan_sequencer_control adc_scan_checker u_adc_scan_checker (.*);
